// File: rtl/rnp_pkg.sv
// Operation
// (RULE_01) each region has own permission register
// (RULE_02) write enables in bits 31 to 16
// (RULE_03) read enables in bits 15 to 0
// (RULE_04) set write bit lets write proceed
// (RULE_05) set read bit lets read proceed
// (RULE_06) filter enable gates region; region zero always
// (RULE_07) clear selected bit means access not permitted
`default_nettype none
package rnp_pkg;
    // ------------------------------------------------------------
    // widths and counts
    // ------------------------------------------------------------
    localparam int unsigned RNP_ADDR_W = 12;
    localparam int unsigned RNP_DATA_W = 32;
    localparam int unsigned RNP_ID_W = 4;
    localparam int unsigned RNP_REGIONS = 8;
    localparam int unsigned RNP_FILTERS = 4;
    localparam int unsigned RNP_CNT_W = 16;

    // ------------------------------------------------------------
    // permission register field positions
    // ------------------------------------------------------------
    localparam int unsigned RNP_WR_LSB = 16;
    localparam int unsigned RNP_RD_LSB = 0;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] RNP_PERM_BASE = 12'h000;
    localparam logic [11:0] RNP_FEN_BASE = 12'h100;
    localparam logic [11:0] RNP_REG_STRIDE = 12'h004;
    localparam logic [11:0] RNP_STATUS = 12'h200;
    localparam logic [11:0] RNP_RD_DENY = 12'h204;
    localparam logic [11:0] RNP_WR_DENY = 12'h208;
    localparam logic [11:0] RNP_CONFIG = 12'h20c;

    // ------------------------------------------------------------
    // status and config field positions
    // ------------------------------------------------------------
    localparam int unsigned RNP_STAT_RD_LSB = 0;
    localparam int unsigned RNP_STAT_WR_LSB = 16;
    localparam int unsigned RNP_CFG_REG_LSB = 0;
    localparam int unsigned RNP_CFG_FLT_LSB = 8;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] RNP_PERM_RESET = 32'h0000_0000;
    localparam logic [31:0] RNP_DATA_RESET = 32'h0000_0000;
endpackage
`default_nettype wire

// File: rtl/rnp_chk_if.sv
`timescale 1ns/1ns
`default_nettype none
interface rnp_chk_if #(
    parameter int unsigned NR = rnp_pkg::RNP_REGIONS,
    parameter int unsigned NF = rnp_pkg::RNP_FILTERS
);
    // region programming
    logic [NR-1:0][31:0] perm;
    logic [NR-1:0][NF-1:0] fen;
    // per filter requests
    logic [NF-1:0] rd_req;
    logic [NF-1:0][rnp_pkg::RNP_ID_W-1:0] rd_id;
    logic [NF-1:0][NR-1:0] rd_hit;
    logic [NF-1:0] wr_req;
    logic [NF-1:0][rnp_pkg::RNP_ID_W-1:0] wr_id;
    logic [NF-1:0][NR-1:0] wr_hit;
    // per filter decisions
    logic [NF-1:0] rd_ok;
    logic [NF-1:0] wr_ok;

    modport top (
        output perm, fen, rd_req, rd_id, rd_hit, wr_req, wr_id, wr_hit,
        input rd_ok, wr_ok
    );
    modport chk (
        input perm, fen, rd_req, rd_id, rd_hit, wr_req, wr_id, wr_hit,
        output rd_ok, wr_ok
    );
endinterface
`default_nettype wire

// File: rtl/rnp_check.sv
`timescale 1ns/1ns
`default_nettype none
module rnp_check #(
    parameter int unsigned NR = rnp_pkg::RNP_REGIONS,
    parameter int unsigned NF = rnp_pkg::RNP_FILTERS
) (
    // decision channel
    rnp_chk_if.chk chk
);
    // ------------------------------------------------------------
    // identifier permission lookup
    // ------------------------------------------------------------
    // highest numbered enabled region that matches decides
    function automatic logic id_grant(
        input logic [NR-1:0][31:0] perm,
        input logic [NR-1:0][NF-1:0] fen,
        input logic [NR-1:0] hit,
        input int unsigned f,
        input logic [rnp_pkg::RNP_ID_W-1:0] id,
        input logic is_wr
    );
        logic ok;
        logic [4:0] pos;
        ok = 1'b0;
        pos = 5'h00;
        for (int unsigned n = 0; n < NR; n++) begin
            // (RULE_06) filter enable gating
            if (hit[n] && (fen[n][f] || n == 0)) begin
                // (RULE_02) write bit select
                if (is_wr) begin
                    pos = 5'(rnp_pkg::RNP_WR_LSB) + {1'b0, id};
                // (RULE_03) read bit select
                end else begin
                    pos = 5'(rnp_pkg::RNP_RD_LSB) + {1'b0, id};
                end
                // (RULE_07) clear bit denies
                ok = perm[n][pos];
            end
        end
        return ok;
    endfunction

    // ------------------------------------------------------------
    // per filter decisions
    // ------------------------------------------------------------
    always_comb begin
        for (int unsigned f = 0; f < NF; f++) begin
            // (RULE_05) read grant check
            chk.rd_ok[f] = chk.rd_req[f] &&
                id_grant(chk.perm, chk.fen, chk.rd_hit[f], f, chk.rd_id[f], 1'b0);
            // (RULE_04) write grant check
            chk.wr_ok[f] = chk.wr_req[f] &&
                id_grant(chk.perm, chk.fen, chk.wr_hit[f], f, chk.wr_id[f], 1'b1);
        end
    end
endmodule // rnp_check
`default_nettype wire

// File: rtl/rnp_top.sv
`timescale 1ns/1ns
`default_nettype none
module rnp_top #(
    parameter int unsigned NR = rnp_pkg::RNP_REGIONS,
    parameter int unsigned NF = rnp_pkg::RNP_FILTERS,
    parameter int unsigned CW = rnp_pkg::RNP_CNT_W
) (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    // register port
    input wire logic [rnp_pkg::RNP_ADDR_W-1:0] reg_addr,
    input wire logic [rnp_pkg::RNP_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [rnp_pkg::RNP_DATA_W-1:0] reg_rdata,
    // filter read requests
    input wire logic [NF-1:0] rd_req,
    input wire logic [NF-1:0][rnp_pkg::RNP_ID_W-1:0] read_access_id_input,
    input wire logic [NF-1:0][NR-1:0] rd_region_hit,
    // filter write requests
    input wire logic [NF-1:0] wr_req,
    input wire logic [NF-1:0][rnp_pkg::RNP_ID_W-1:0] write_access_id_input,
    input wire logic [NF-1:0][NR-1:0] wr_region_hit,
    // filter read decisions
    output logic [NF-1:0] rd_permit,
    output logic [NF-1:0] rd_done,
    // filter write decisions
    output logic [NF-1:0] wr_permit,
    output logic [NF-1:0] wr_done
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [NR-1:0][31:0] perm;
        logic [NR-1:0][NF-1:0] fen;
        logic [31:0] rdata;
        logic [NF-1:0] rd_permit;
        logic [NF-1:0] rd_done;
        logic [NF-1:0] wr_permit;
        logic [NF-1:0] wr_done;
        logic [CW-1:0] rd_deny;
        logic [CW-1:0] wr_deny;
    } rnp_state_t;

    rnp_state_t state;
    rnp_state_t next_state;

    // decision channel to the checker
    rnp_chk_if #(.NR(NR), .NF(NF)) chk_bus ();

    logic [NF-1:0] rd_refused;
    logic [NF-1:0] wr_refused;
    logic rd_deny_clr;
    logic wr_deny_clr;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // register address of entry n in a per region bank
    function automatic logic bank_hit(
        input logic [11:0] addr,
        input logic [11:0] base,
        input int unsigned n
    );
        logic [11:0] where;
        where = base + 12'(n) * rnp_pkg::RNP_REG_STRIDE;
        return addr == where;
    endfunction

    // saturating add of the number of refused filters
    function automatic logic [CW-1:0] sat_add(
        input logic [CW-1:0] cnt,
        input logic [NF-1:0] mask
    );
        logic [CW:0] sum;
        sum = {1'b0, cnt};
        for (int unsigned f = 0; f < NF; f++) begin
            if (mask[f] && sum[CW-1:0] != {CW{1'b1}}) begin
                sum = sum + {{CW{1'b0}}, 1'b1};
            end
        end
        return sum[CW-1:0];
    endfunction

    // ------------------------------------------------------------
    // checker connection
    // ------------------------------------------------------------
    // (RULE_01) every region programming goes to the checker
    assign chk_bus.perm = state.perm;
    assign chk_bus.fen = state.fen;
    assign chk_bus.rd_req = rd_req;
    assign chk_bus.rd_id = read_access_id_input;
    assign chk_bus.rd_hit = rd_region_hit;
    assign chk_bus.wr_req = wr_req;
    assign chk_bus.wr_id = write_access_id_input;
    assign chk_bus.wr_hit = wr_region_hit;

    rnp_check #(
        .NR(NR),
        .NF(NF)
    ) u_check (
        .chk(chk_bus.chk)
    );

    // ------------------------------------------------------------
    // refusals and counter clears
    // ------------------------------------------------------------
    // (RULE_07) requests without a set enable bit are refused
    assign rd_refused = rd_req & ~chk_bus.rd_ok;
    assign wr_refused = wr_req & ~chk_bus.wr_ok;
    // a write to a counter clears it
    assign rd_deny_clr = reg_wr && reg_addr == rnp_pkg::RNP_RD_DENY;
    assign wr_deny_clr = reg_wr && reg_addr == rnp_pkg::RNP_WR_DENY;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;

        // register writes
        if (reg_wr) begin
            for (int unsigned n = 0; n < NR; n++) begin
                // (RULE_01) one permission word per region
                if (bank_hit(reg_addr, rnp_pkg::RNP_PERM_BASE, n)) begin
                    next_state.perm[n] = reg_wdata;
                end
                // region zero enables are fixed
                if (n != 0 && bank_hit(reg_addr, rnp_pkg::RNP_FEN_BASE, n)) begin
                    next_state.fen[n] = reg_wdata[NF-1:0];
                end
            end
        end

        // (RULE_06) region zero enabled in every filter
        next_state.fen[0] = {NF{1'b1}};

        // register reads, data stand one cycle only
        next_state.rdata = rnp_pkg::RNP_DATA_RESET;
        if (reg_rd) begin
            for (int unsigned n = 0; n < NR; n++) begin
                if (bank_hit(reg_addr, rnp_pkg::RNP_PERM_BASE, n)) begin
                    next_state.rdata = state.perm[n];
                end
                if (bank_hit(reg_addr, rnp_pkg::RNP_FEN_BASE, n)) begin
                    next_state.rdata[NF-1:0] = state.fen[n];
                end
            end
            case (reg_addr)
                rnp_pkg::RNP_STATUS: begin
                    next_state.rdata[rnp_pkg::RNP_STAT_RD_LSB +: NF] = state.rd_permit;
                    next_state.rdata[rnp_pkg::RNP_STAT_WR_LSB +: NF] = state.wr_permit;
                end
                rnp_pkg::RNP_RD_DENY: begin
                    next_state.rdata[CW-1:0] = state.rd_deny;
                end
                rnp_pkg::RNP_WR_DENY: begin
                    next_state.rdata[CW-1:0] = state.wr_deny;
                end
                rnp_pkg::RNP_CONFIG: begin
                    next_state.rdata[rnp_pkg::RNP_CFG_REG_LSB +: 8] = 8'(NR);
                    next_state.rdata[rnp_pkg::RNP_CFG_FLT_LSB +: 8] = 8'(NF);
                end
                default: begin
                    next_state.rdata = next_state.rdata; // unmapped reads zero
                end
            endcase
        end

        // decision outputs, done pulses per request, permit holds until the next request
        next_state.rd_done = rd_req;
        next_state.wr_done = wr_req;
        for (int unsigned f = 0; f < NF; f++) begin
            // (RULE_05) read may proceed
            if (rd_req[f]) begin
                next_state.rd_permit[f] = chk_bus.rd_ok[f];
            end
            // (RULE_04) write may proceed
            if (wr_req[f]) begin
                next_state.wr_permit[f] = chk_bus.wr_ok[f];
            end
        end

        // refusal counters, new refusal wins over clear
        next_state.rd_deny = sat_add(rd_deny_clr ? {CW{1'b0}} : state.rd_deny, rd_refused);
        next_state.wr_deny = sat_add(wr_deny_clr ? {CW{1'b0}} : state.wr_deny, wr_refused);

        // synchronous reset
        if (!rst_n) begin
            next_state.perm = {NR{rnp_pkg::RNP_PERM_RESET}};
            next_state.fen = '0;
            next_state.fen[0] = {NF{1'b1}};
            next_state.rdata = rnp_pkg::RNP_DATA_RESET;
            next_state.rd_permit = '0;
            next_state.rd_done = '0;
            next_state.wr_permit = '0;
            next_state.wr_done = '0;
            next_state.rd_deny = '0;
            next_state.wr_deny = '0;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // reset acts even while the enable is low
    always_ff @(posedge sys_clk) begin
        if (ce || !rst_n) begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata = state.rdata;
    assign rd_permit = state.rd_permit;
    assign rd_done = state.rd_done;
    assign wr_permit = state.wr_permit;
    assign wr_done = state.wr_done;
endmodule // rnp_top
`default_nettype wire

// File: verif/rnp_master_model.sv
`timescale 1ns/1ns
`default_nettype none
module rnp_master_model #(
    parameter int unsigned NR = rnp_pkg::RNP_REGIONS,
    parameter int unsigned NF = rnp_pkg::RNP_FILTERS
) (
    // clock
    input wire logic sys_clk,
    // read requests
    output logic [NF-1:0] rd_req,
    output logic [NF-1:0][rnp_pkg::RNP_ID_W-1:0] rd_id,
    output logic [NF-1:0][NR-1:0] rd_hit,
    // write requests
    output logic [NF-1:0] wr_req,
    output logic [NF-1:0][rnp_pkg::RNP_ID_W-1:0] wr_id,
    output logic [NF-1:0][NR-1:0] wr_hit
);
    // idle masters at time zero
    initial begin
        {rd_req, rd_id, rd_hit, wr_req, wr_id, wr_hit} = '0;
    end

    // one access: held for its taking edge, then released with inverted lines
    task automatic issue(input logic is_wr, input int f, input logic [3:0] id, input logic [NR-1:0] hit);
        @(posedge sys_clk);
        if (is_wr) begin
            wr_req[f] <= 1'b1;
            wr_id[f] <= id;
            wr_hit[f] <= hit;
        end else begin
            rd_req[f] <= 1'b1;
            rd_id[f] <= id;
            rd_hit[f] <= hit;
        end
        @(posedge sys_clk);
        if (is_wr) begin
            wr_req[f] <= 1'b0;
            wr_id[f] <= ~id;
            wr_hit[f] <= ~hit;
        end else begin
            rd_req[f] <= 1'b0;
            rd_id[f] <= ~id;
            rd_hit[f] <= ~hit;
        end
    endtask
endmodule // rnp_master_model
`default_nettype wire

// File: verif/rnp_top_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module rnp_top_assertions #(
    parameter int unsigned NR = rnp_pkg::RNP_REGIONS,
    parameter int unsigned NF = rnp_pkg::RNP_FILTERS
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    // register port
    input wire logic [rnp_pkg::RNP_ADDR_W-1:0] reg_addr,
    input wire logic [rnp_pkg::RNP_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [rnp_pkg::RNP_DATA_W-1:0] reg_rdata,
    // requests
    input wire logic [NF-1:0] rd_req,
    input wire logic [NF-1:0][rnp_pkg::RNP_ID_W-1:0] read_access_id_input,
    input wire logic [NF-1:0][NR-1:0] rd_region_hit,
    input wire logic [NF-1:0] wr_req,
    input wire logic [NF-1:0][rnp_pkg::RNP_ID_W-1:0] write_access_id_input,
    input wire logic [NF-1:0][NR-1:0] wr_region_hit,
    // decisions
    input wire logic [NF-1:0] rd_permit,
    input wire logic [NF-1:0] rd_done,
    input wire logic [NF-1:0] wr_permit,
    input wire logic [NF-1:0] wr_done
);
    logic [31:0] perm0;
    logic exp_rd;
    logic exp_wr;
    // shadow of region zero word and the bits the ids select
    always_ff @(posedge sys_clk) begin
        exp_rd <= perm0[read_access_id_input[0]];
        exp_wr <= perm0[16 + write_access_id_input[1]];
        if (!rst_n)
            perm0 <= 32'h0000_0000;
        else if (ce && reg_wr && reg_addr == rnp_pkg::RNP_PERM_BASE)
            perm0 <= reg_wdata;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    rd_done_pulse_a: assert property (ce |=> rd_done == $past(rd_req))
        else $error("read done does not follow request");
    wr_done_pulse_a: assert property (ce |=> wr_done == $past(wr_req))
        else $error("write done does not follow request");
    no_hit_deny_a: assert property (ce && rd_req[0] && rd_region_hit[0] == '0 |=> !rd_permit[0])
        else $error("read without region permitted");
    permit_hold_a: assert property (ce && !wr_req[1] |=> $stable(wr_permit[1]))
        else $error("write permit moved without request");
    rd_id_bit_a: assert property (ce && rd_req[0] && rd_region_hit[0] == NR'(1) |=> rd_permit[0] == exp_rd)
        else $error("read permit differs from id bit");
    wr_id_bit_a: assert property (ce && wr_req[1] && wr_region_hit[1] == NR'(1) |=> wr_permit[1] == exp_wr)
        else $error("write permit differs from id bit");
    perm_readback_a: assert property (ce && reg_rd && reg_addr == rnp_pkg::RNP_PERM_BASE |=> reg_rdata == $past(perm0))
        else $error("region zero word readback wrong");
    fen_fixed_a: assert property (ce && reg_rd && reg_addr == rnp_pkg::RNP_FEN_BASE |=> reg_rdata == 32'((1 << NF) - 1))
        else $error("region zero filter enables not all set");
    rd_grant_c: cover property (rd_req[0] ##1 rd_permit[0]);
    wr_deny_c: cover property (wr_req[1] ##1 !wr_permit[1]);
    fen_read_c: cover property (reg_rd && reg_addr == rnp_pkg::RNP_FEN_BASE);
endmodule // rnp_top_assertions
bind rnp_top rnp_top_assertions #(.NR(NR), .NF(NF)) u_rnp_assert (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rd_req(rd_req), .read_access_id_input(read_access_id_input), .rd_region_hit(rd_region_hit),
    .wr_req(wr_req), .write_access_id_input(write_access_id_input), .wr_region_hit(wr_region_hit),
    .rd_permit(rd_permit), .rd_done(rd_done), .wr_permit(wr_permit), .wr_done(wr_done));
`default_nettype wire

// File: verif/region_nonsecure_id_permission_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module region_nonsecure_id_permission_tb_top;
    localparam int NR = rnp_pkg::RNP_REGIONS;
    localparam int NF = rnp_pkg::RNP_FILTERS;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [NF-1:0] rd_req, wr_req, rd_permit, rd_done, wr_permit, wr_done;
    logic [NF-1:0][3:0] rd_id, wr_id;
    logic [NF-1:0][NR-1:0] rd_hit, wr_hit;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;

    // 10 MHz clock
    always #50 sys_clk = ~sys_clk;

    rnp_master_model #(.NR(NR), .NF(NF)) u_mst (.sys_clk(sys_clk), .rd_req(rd_req), .rd_id(rd_id),
        .rd_hit(rd_hit), .wr_req(wr_req), .wr_id(wr_id), .wr_hit(wr_hit));
    rnp_top #(.NR(NR), .NF(NF)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rd_req(rd_req),
        .read_access_id_input(rd_id), .rd_region_hit(rd_hit), .wr_req(wr_req), .write_access_id_input(wr_id),
        .wr_region_hit(wr_hit), .rd_permit(rd_permit), .rd_done(rd_done), .wr_permit(wr_permit),
        .wr_done(wr_done));

    // ------------------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [11:0] a, input logic [31:0] exp, input string what);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(what, reg_rdata, exp);
    endtask

    task automatic access(input logic is_wr, input int f, input logic [3:0] id, input logic [NR-1:0] hit,
                          input logic exp);
        u_mst.issue(is_wr, f, id, hit);
        #1;
        chk("done", is_wr ? wr_done[f] : rd_done[f], 32'h0000_0001);
        chk("permit", is_wr ? wr_permit[f] : rd_permit[f], {31'h0000_0000, exp});
    endtask

    // hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            final_report();
        end
    end

    // main sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int n = 0; n < NR; n++) begin
            reg_read(rnp_pkg::RNP_PERM_BASE + 12'(4 * n), 32'h0000_0000, "perm_reset");
        end
        reg_read(rnp_pkg::RNP_FEN_BASE, 32'h0000_000f, "fen0_reset");
        reg_read(rnp_pkg::RNP_FEN_BASE + 12'h004, 32'h0000_0000, "fen1_reset");
        reg_read(12'hffc, 32'h0000_0000, "unmapped");
        for (int n = 0; n < NR; n++) begin
            reg_write(rnp_pkg::RNP_PERM_BASE + 12'(4 * n), 32'h0101_0101 * (n + 1));
        end
        for (int n = 0; n < NR; n++) begin
            reg_read(rnp_pkg::RNP_PERM_BASE + 12'(4 * n), 32'h0101_0101 * (n + 1), "perm_word");
        end
        // walk every id through both halves of region zero
        for (int k = 0; k < 16; k++) begin
            reg_write(rnp_pkg::RNP_PERM_BASE, 32'h0000_0001 << (16 + k));
            access(1'b0, k % NF, 4'(k), NR'(1), 1'b0);
            access(1'b1, k % NF, 4'(k), NR'(1), 1'b1);
            access(1'b1, (k + 1) % NF, 4'(k + 1), NR'(1), 1'b0);
            reg_write(rnp_pkg::RNP_PERM_BASE, 32'h0000_0001 << k);
            access(1'b0, k % NF, 4'(k), NR'(1), 1'b1);
            access(1'b0, (k + 1) % NF, 4'(k + 1), NR'(1), 1'b0);
            access(1'b1, k % NF, 4'(k), NR'(1), 1'b0);
        end
        // per filter region enables
        reg_write(rnp_pkg::RNP_PERM_BASE + 12'h004, 32'hffff_ffff);
        reg_write(rnp_pkg::RNP_PERM_BASE, 32'h0000_0000);
        access(1'b0, 2, 4'h5, NR'(2), 1'b0);
        reg_write(rnp_pkg::RNP_FEN_BASE + 12'h004, 32'h0000_0004);
        access(1'b0, 2, 4'h5, NR'(3), 1'b1);
        access(1'b1, 3, 4'h5, NR'(3), 1'b0);
        reg_write(rnp_pkg::RNP_FEN_BASE, 32'h0000_0000);
        reg_read(rnp_pkg::RNP_FEN_BASE, 32'h0000_000f, "fen0_fixed");
        access(1'b0, 0, 4'h5, NR'(0), 1'b0);
        // refusal counters, status and config after the walks above
        reg_read(rnp_pkg::RNP_RD_DENY, 32'h0000_0022, "rd_deny_count");
        reg_read(rnp_pkg::RNP_WR_DENY, 32'h0000_0021, "wr_deny_count");
        reg_read(rnp_pkg::RNP_STATUS, 32'h0000_000e, "status");
        reg_read(rnp_pkg::RNP_CONFIG, {16'h0000, 8'(NF), 8'(NR)}, "config");
        reg_write(rnp_pkg::RNP_RD_DENY, 32'h0000_0000);
        reg_read(rnp_pkg::RNP_RD_DENY, 32'h0000_0000, "rd_deny_clr");
        // enable low freezes register writes and requests
        @(posedge sys_clk);
        ce <= 1'b0;
        reg_write(rnp_pkg::RNP_PERM_BASE, 32'hffff_ffff);
        u_mst.issue(1'b0, 1, 4'h0, NR'(1));
        #1;
        chk("frozen_done", rd_done[1], 32'h0000_0000);
        chk("frozen_permit", rd_permit[1], 32'h0000_0001);
        @(posedge sys_clk);
        ce <= 1'b1;
        reg_read(rnp_pkg::RNP_PERM_BASE, 32'h0000_0000, "frozen_perm");
        reg_read(rnp_pkg::RNP_RD_DENY, 32'h0000_0000, "frozen_deny");
        final_report();
    end
endmodule // region_nonsecure_id_permission_tb_top
`default_nettype wire
